//--- rtl/icr_pkg.sv
// package of constants and types for the two-wire configuration register slave
package icr_pkg;

    // ------------------------------------------------------------
    // bus address and register map
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h46;
    localparam logic [7:0] REG_NB_TRIM = 8'h00;
    localparam logic [7:0] REG_CORE_TRIM = 8'h01;
    localparam logic [7:0] REG_PSAVE = 8'h02;
    localparam logic [7:0] REG_COUNT = 8'h03;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] NB_TRIM_RESET = 8'h00;
    localparam logic [7:0] CORE_TRIM_RESET = 8'h00;
    localparam logic [7:0] PSAVE_RESET = 8'h01;
    localparam logic [7:0] RELEASED_BYTE = 8'hff;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic LINE_IDLE = 1'b1;

    // ------------------------------------------------------------
    // link timing: fast-mode clock high time against link sampling
    // ------------------------------------------------------------
    localparam int LINK_PERIOD_NS = 12;
    localparam int FM_SCL_HIGH_NS = 600;
    localparam int FM_SCL_HIGH_CYC = FM_SCL_HIGH_NS / LINK_PERIOD_NS;
    localparam int EDGE_DETECT_CYC = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TXACK = 3'b100,
        ST_WAIT = 3'b101
    } icr_state_t;

    typedef enum logic [1:0] {
        K_CTRL = 2'b00,
        K_PTR = 2'b01,
        K_DATA = 2'b10
    } icr_kind_t;

    typedef struct packed {
        logic ovp_raise;
        logic pgood_raise;
        logic [5:0] offset;
    } icr_trim_t;

    typedef struct packed {
        logic reserved;
        logic core_offset_off;
        logic [1:0] drop_gap;
        logic [1:0] add_gap;
        logic [1:0] shed_phases;
    } icr_psave_t;

    typedef struct packed {
        icr_psave_t psave;
        icr_trim_t core;
        icr_trim_t nb;
    } icr_cfg_t;

    localparam icr_cfg_t CFG_RESET = icr_cfg_t'({PSAVE_RESET, CORE_TRIM_RESET, NB_TRIM_RESET});

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        logic por_s1;
        logic por_s2;
        icr_state_t state;
        icr_kind_t kind;
        logic rw;
        logic [2:0] cnt;
        logic full;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic master_ack;
        logic dirty;
        logic pend;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic [2:0][7:0] shadow;
        logic [2:0][7:0] xfer;
        logic sda_oe;
        logic sda_o;
    } icr_link_t;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_d;
        logic por_s1;
        logic por_s2;
        icr_cfg_t cfg;
        logic update;
    } icr_core_t;

endpackage

//--- rtl/icr_slave.sv
// two-wire slave holding the three regulator configuration registers
`timescale 1ns/1ps
`default_nettype none

module icr_slave
    import icr_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic link_clk_in,
    input wire logic supply_ok_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output var icr_cfg_t cfg_out,
    output logic cfg_update_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] read_reg(input logic [2:0][7:0] regs, input logic [7:0] idx);
        logic [7:0] val;
        val = RELEASED_BYTE;
        if (idx < REG_COUNT)
        begin
            val = regs[idx[1:0]];
        end
        return val;
    endfunction

    function automatic logic [7:0] step_ptr(input logic [7:0] idx);
        return 8'(idx + 8'h01);
    endfunction

    // ------------------------------------------------------------
    // link domain state
    // ------------------------------------------------------------
    icr_link_t l;
    icr_link_t next_l;
    icr_core_t c;
    icr_core_t next_c;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;

    // three samples of each line: the first flop feeds only the second
    assign start_det = l.scl_s2 && l.scl_d && l.sda_d && !l.sda_s2;
    assign stop_det = l.scl_s2 && l.scl_d && !l.sda_d && l.sda_s2;
    assign scl_rise = l.scl_s2 && !l.scl_d;
    assign scl_fall = !l.scl_s2 && l.scl_d;

    always_comb
    begin
        next_l = l;
        next_l.scl_s1 = scl_in;
        next_l.scl_s2 = l.scl_s1;
        next_l.scl_d = l.scl_s2;
        next_l.sda_s1 = sda_in;
        next_l.sda_s2 = l.sda_s1;
        next_l.sda_d = l.sda_s2;
        next_l.por_s1 = supply_ok_in;
        next_l.por_s2 = l.por_s1;
        next_l.ack_s1 = c.req_d;
        next_l.ack_s2 = l.ack_s1;
        // the line is only ever pulled low, never driven high
        next_l.sda_o = 1'b0;
        if (!l.por_s2)
        begin
            // below the power-on threshold the slave is deaf and mute
            next_l.state = ST_IDLE;
            next_l.sda_oe = 1'b0;
            next_l.shadow = CFG_RESET;
            next_l.ptr = REG_NB_TRIM;
            next_l.full = 1'b0;
            next_l.cnt = BIT_CNT_RESET;
            next_l.dirty = 1'b0;
            next_l.pend = 1'b0;
        end
        else if (start_det)
        begin
            // a start mid-transfer simply restarts the control byte
            next_l.state = ST_RX;
            next_l.kind = K_CTRL;
            next_l.cnt = BIT_CNT_RESET;
            next_l.full = 1'b0;
            next_l.sda_oe = 1'b0;
        end
        else if (stop_det)
        begin
            next_l.state = ST_IDLE;
            next_l.sda_oe = 1'b0;
            next_l.full = 1'b0;
            if (l.dirty)
            begin
                next_l.pend = 1'b1;
                next_l.dirty = 1'b0;
            end
        end
        else
        begin
            case (l.state)
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        next_l.shift = {l.shift[6:0], l.sda_s2};
                        next_l.cnt = 3'(l.cnt + 3'h1);
                        if (l.cnt == BIT_CNT_LAST)
                        begin
                            next_l.full = 1'b1;
                        end
                    end
                    else if (scl_fall && l.full)
                    begin
                        next_l.full = 1'b0;
                        next_l.cnt = BIT_CNT_RESET;
                        next_l.state = ST_WAIT;
                        case (l.kind)
                            K_CTRL:
                            begin
                                if (l.shift[7:1] == SLAVE_ADDR)
                                begin
                                    next_l.rw = l.shift[0];
                                    next_l.sda_oe = 1'b1;
                                    next_l.state = ST_ACK;
                                end
                            end
                            K_PTR:
                            begin
                                if (l.shift < REG_COUNT)
                                begin
                                    next_l.ptr = l.shift;
                                    next_l.sda_oe = 1'b1;
                                    next_l.state = ST_ACK;
                                end
                            end
                            default:
                            begin
                                if (l.ptr < REG_COUNT)
                                begin
                                    next_l.shadow[l.ptr[1:0]] = l.shift;
                                    next_l.ptr = step_ptr(l.ptr);
                                    next_l.dirty = 1'b1;
                                    next_l.sda_oe = 1'b1;
                                    next_l.state = ST_ACK;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    // release after the ninth clock falls; a read ack drives the first data bit instead
                    if (scl_fall)
                    begin
                        next_l.sda_oe = 1'b0;
                        next_l.cnt = BIT_CNT_RESET;
                        if (l.kind == K_CTRL && l.rw)
                        begin
                            next_l.shift = read_reg(l.shadow, l.ptr);
                            next_l.sda_oe = !next_l.shift[7];
                            next_l.state = ST_TX;
                        end
                        else
                        begin
                            next_l.kind = (l.kind == K_CTRL) ? K_PTR : K_DATA;
                            next_l.state = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    // bits change only on the falling clock
                    if (scl_fall)
                    begin
                        if (l.cnt == BIT_CNT_LAST)
                        begin
                            next_l.sda_oe = 1'b0;
                            next_l.state = ST_TXACK;
                        end
                        else
                        begin
                            next_l.shift = {l.shift[6:0], 1'b1};
                            next_l.sda_oe = !l.shift[6];
                            next_l.cnt = 3'(l.cnt + 3'h1);
                        end
                    end
                end
                ST_TXACK:
                begin
                    if (scl_rise)
                    begin
                        next_l.master_ack = !l.sda_s2;
                    end
                    else if (scl_fall)
                    begin
                        next_l.state = ST_WAIT;
                        if (l.master_ack)
                        begin
                            next_l.ptr = step_ptr(l.ptr);
                            if (step_ptr(l.ptr) < REG_COUNT)
                            begin
                                next_l.shift = read_reg(l.shadow, step_ptr(l.ptr));
                                next_l.sda_oe = !next_l.shift[7];
                                next_l.cnt = BIT_CNT_RESET;
                                next_l.state = ST_TX;
                            end
                        end
                    end
                end
                default:
                begin
                    next_l.sda_oe = 1'b0;
                end
            endcase
        end
        // hand the finished set over; held stable until the core side echoes
        if (next_l.pend && l.req == l.ack_s2 && l.por_s2)
        begin
            next_l.xfer = next_l.shadow;
            next_l.req = !l.req;
            next_l.pend = 1'b0;
        end
    end

    always_ff @(posedge link_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            l <= '0;
            // line samples start at the idle level, so no false edge follows reset
            l.scl_s1 <= LINE_IDLE;
            l.scl_s2 <= LINE_IDLE;
            l.scl_d <= LINE_IDLE;
            l.sda_s1 <= LINE_IDLE;
            l.sda_s2 <= LINE_IDLE;
            l.sda_d <= LINE_IDLE;
            l.shadow <= CFG_RESET;
            l.xfer <= CFG_RESET;
            l.ptr <= REG_NB_TRIM;
        end
        else
        begin
            l <= next_l;
        end
    end

    // ------------------------------------------------------------
    // core domain: applied configuration
    // ------------------------------------------------------------
    always_comb
    begin
        next_c = c;
        next_c.req_s1 = l.req;
        next_c.req_s2 = c.req_s1;
        next_c.por_s1 = supply_ok_in;
        next_c.por_s2 = c.por_s1;
        next_c.update = 1'b0;
        if (c.req_s2 != c.req_d)
        begin
            next_c.req_d = c.req_s2;
            if (c.por_s2)
            begin
                // trim fields map bit 7, bit 6 and bits 5..0 straight out
                next_c.cfg = icr_cfg_t'(l.xfer);
                next_c.update = 1'b1;
            end
        end
        if (!c.por_s2)
        begin
            next_c.cfg = CFG_RESET;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            c <= '0;
            c.cfg <= CFG_RESET;
        end
        else
        begin
            c <= next_c;
        end
    end

    // the clock pin is an input only; the slave never drives it
    assign sda_out = l.sda_o;
    assign sda_oe_out = l.sda_oe;
    assign cfg_out = c.cfg;
    assign cfg_update_out = c.update;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // fast-mode high time must span the sync delay, or a rising clock is lost
    localparam bit RATE_OK = FM_SCL_HIGH_CYC > EDGE_DETECT_CYC;

    rate_margin_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        (RATE_OK && l.por_s2 && !start_det && !stop_det && l.state == ST_RX && scl_rise)
            |=> (l.cnt == 3'($past(l.cnt) + 3'h1)))
        else $error("received bit not counted");

    drive_low_only_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        sda_oe_out |-> !sda_out)
        else $error("data line driven high");

    drive_clock_low_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        $rose(sda_oe_out) |-> !l.scl_d)
        else $error("data line changed while clock high");

    start_restart_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        (start_det && l.por_s2) |=> (l.state == ST_RX && l.kind == K_CTRL && l.cnt == BIT_CNT_RESET))
        else $error("start not taken");

    stop_release_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        (stop_det && l.por_s2) |=> (l.state == ST_IDLE && !sda_oe_out))
        else $error("stop not taken");

    foreign_nack_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        (l.por_s2 && !start_det && !stop_det && l.state == ST_RX && l.kind == K_CTRL && scl_fall && l.full
            && l.shift[7:1] != SLAVE_ADDR) |=> (l.state == ST_WAIT && !sda_oe_out) [*2])
        else $error("foreign address acknowledged");

    ack_release_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        (l.por_s2 && !start_det && !stop_det && l.state == ST_ACK && scl_fall && !(l.kind == K_CTRL && l.rw))
            |=> !sda_oe_out)
        else $error("acknowledge held past ninth clock");

    range_guard_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        (l.state == ST_RX && l.kind == K_DATA && l.ptr >= REG_COUNT && l.por_s2) |=> $stable(l.shadow))
        else $error("write beyond last register");

    ptr_refuse_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        (l.por_s2 && !start_det && !stop_det && l.state == ST_RX && l.kind == K_PTR && scl_fall && l.full
            && l.shift >= REG_COUNT) |=> (l.state == ST_WAIT && !sda_oe_out && $stable(l.ptr)))
        else $error("pointer beyond last register taken");

    read_advance_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        (l.por_s2 && !start_det && !stop_det && l.state == ST_TXACK && scl_fall && l.master_ack)
            |=> (l.ptr == 8'($past(l.ptr) + 8'h01)))
        else $error("read pointer not advanced");

    supply_clear_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
        !l.por_s2 |=> (l.shadow == CFG_RESET && l.state == ST_IDLE && !sda_oe_out))
        else $error("registers kept below power-on threshold");

    apply_update_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (c.req_s2 != c.req_d && c.por_s2) |=> (cfg_update_out && cfg_out == $past(l.xfer)))
        else $error("written set not applied");

endmodule

`default_nettype wire

//--- verification/icr_master_model.sv
// bus master model that drives the two-wire clock and data lines
`timescale 1ns/1ps
`default_nettype none

module icr_master_model (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // one third of a bit: 12 core cycles, above the 3 link clocks the slave needs
    localparam int QTR = 12;

    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic pace();
        repeat (QTR) @(negedge clk_in);
    endtask

    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    task automatic start();
        sda_low_out = 1'b0;
        scl_out = 1'b1;
        pace();
        sda_low_out = 1'b1;
        pace();
        scl_out = 1'b0;
        pace();
    endtask

    // every transaction is closed here before the next start
    task automatic stop();
        sda_low_out = 1'b1;
        pace();
        scl_out = 1'b1;
        pace();
        sda_low_out = 1'b0;
        pace();
    endtask

    // ------------------------------------------------------------
    // nine clocks: eight bits msb first, then the acknowledge slot
    // ------------------------------------------------------------
    task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low_out = !tx[i];
            pace();
            scl_out = 1'b1;
            pace();
            rx[i] = sda_in;
            scl_out = 1'b0;
            pace();
        end
        sda_low_out = 1'b0;
    endtask
endmodule

`default_nettype wire

//--- verification/icr_slave_test.sv
// self-checking testbench for the two-wire configuration register slave
`timescale 1ns/1ps
`default_nettype none

module icr_slave_test
    import icr_pkg::*;
;
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
        logic [23:0] cfg;
    } icr_row_t;

    logic clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic supply_ok_in = 1'b1;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe_out;
    icr_cfg_t cfg_out;
    logic cfg_update_out;
    wire logic sda_wire;
    int n_fail = 0;
    int check_count = 0;
    int n_upd = 0;
    logic [7:0] wr_ctrl;
    logic [7:0] rd_ctrl;
    logic [5:0] acks;
    logic [23:0] got;
    icr_row_t rows [3];

    // pulled-up wired-AND line
    assign sda_wire = !(sda_oe_out | sda_low);

    always #5 clk_in = !clk_in;

    initial
    begin
        #3;
        forever #6 link_clk_in = !link_clk_in;
    end

    always @(posedge clk_in)
        if (cfg_update_out === 1'b1)
            n_upd <= n_upd + 1;

    icr_slave i_dut (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .link_clk_in(link_clk_in),
        .supply_ok_in(supply_ok_in),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .cfg_out(cfg_out),
        .cfg_update_out(cfg_update_out)
    );

    icr_master_model i_master (
        .clk_in(clk_in),
        .sda_in(sda_wire),
        .scl_out(scl),
        .sda_low_out(sda_low)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] got_v, input logic [23:0] exp_v, input string what);
        check_count++;
        if (got_v !== exp_v)
        begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got_v, exp_v);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic [8:0] rx;
        i_master.xfer9({b, 1'b1}, rx);
        ack = rx[0];
    endtask

    // a not-acknowledge answers the last byte of a read
    task automatic recv(input logic last, output logic [7:0] d);
        logic [8:0] rx;
        i_master.xfer9({8'hff, last}, rx);
        d = rx[8:1];
    endtask

    // write n data bytes from ptr; acks holds ctrl, ptr, data in that order from bit 5
    task automatic write_regs(input logic [7:0] ptr, input logic [31:0] data, input int n);
        acks = 6'h3f;
        i_master.start();
        send(wr_ctrl, acks[5]);
        send(ptr, acks[4]);
        for (int k = 0; k < n; k++)
            send(data[8*k +: 8], acks[3-k]);
        i_master.stop();
    endtask

    // pointer, stop, then a fresh read of n bytes
    task automatic read_regs(input logic [7:0] ptr, input int n);
        logic a0;
        logic a1;
        logic a2;
        logic [7:0] d;
        got = 24'h0;
        i_master.start();
        send(wr_ctrl, a0);
        send(ptr, a1);
        i_master.stop();
        i_master.start();
        send(rd_ctrl, a2);
        for (int k = 0; k < n; k++)
        begin
            recv(k == n - 1, d);
            got[8*k +: 8] = d;
        end
        i_master.stop();
        check(24'({a0, a1, a2}), 24'h0, "read acks");
    endtask

    task automatic wait_upd(input int target);
        for (int k = 0; k < 60 && n_upd < target; k++)
            @(negedge clk_in);
        check(24'(n_upd), 24'(target), "update pulses");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        wr_ctrl = {SLAVE_ADDR, 1'b0};
        rd_ctrl = {SLAVE_ADDR, 1'b1};
        rows[0] = '{8'h00, 8'ha5, 24'h01_00_a5};
        rows[1] = '{8'h01, 8'h3c, 24'h01_3c_a5};
        rows[2] = '{8'h02, 8'hc6, 24'hc6_3c_a5};
        repeat (2) @(negedge clk_in);
        check(24'(cfg_out), 24'(CFG_RESET), "reset cfg");
        check(24'({sda_oe_out, cfg_update_out}), 24'h0, "reset outputs");
        arst_n_in = 1'b1;
        repeat (20) @(negedge clk_in);

        foreach (rows[i])
        begin
            write_regs(rows[i].ptr, 32'(rows[i].data), 1);
            check(24'(acks[5:3]), 24'h0, "write acks");
            wait_upd(i + 1);
            check(24'(cfg_out), rows[i].cfg, "cfg after write");
            read_regs(rows[i].ptr, 1);
            check(got, 24'(rows[i].data), "single read");
        end
        $display("test single registers done");

        // fourth byte runs past the last register and must be refused
        write_regs(8'h00, 32'h44_33_22_11, 4);
        check(24'(acks), 24'h01, "sequential acks");
        wait_upd(4);
        check(24'(cfg_out), 24'h33_22_11, "sequential cfg");
        read_regs(8'h00, 3);
        check(got, 24'h33_22_11, "sequential read");
        $display("test sequential done");

        write_regs(8'h03, 32'h0000_00ee, 1);
        check(24'(acks[5:3]), 24'h03, "bad pointer acks");
        repeat (60) @(negedge clk_in);
        check(24'(n_upd), 24'h4, "no update");
        check(24'(cfg_out), 24'h33_22_11, "cfg kept");
        $display("test bad pointer done");

        wr_ctrl = {SLAVE_ADDR ^ 7'h01, 1'b0};
        write_regs(8'h00, 32'h0000_0077, 1);
        check(24'(acks[5]), 24'h1, "foreign address nack");
        wr_ctrl = {SLAVE_ADDR, 1'b0};
        $display("test foreign address done");

        supply_ok_in = 1'b0;
        repeat (20) @(negedge clk_in);
        check(24'(cfg_out), 24'(CFG_RESET), "cfg on supply loss");
        write_regs(8'h00, 32'h0000_0055, 1);
        check(24'(acks[5]), 24'h1, "inactive while low");
        supply_ok_in = 1'b1;
        repeat (20) @(negedge clk_in);
        read_regs(8'h00, 3);
        check(got, 24'(CFG_RESET), "initial values read");
        read_regs(8'h02, 2);
        check(got, {8'h00, RELEASED_BYTE, PSAVE_RESET}, "read past last");
        check(24'(sda_out), 24'h0, "drive only low");
        $display("test supply loss done");
        finish_test();
    end

    // run needs about 200 us; a hang is cut off well after that
    initial
    begin
        #800us;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule

`default_nettype wire
